// ---- rtl/port_select_status_regs.sv ----
// Function
// - Self-test CRC errors counted, saturate at 255
// - Counter clears on self-test start or clear
// - Second-port view reads second port's count
// - Status bits report sampled pin levels
// - Status bit layout; reserved bits read zero
// - Second-port view shows remote pins 3..0
// - Address enable adds response at primary+1
// - Second-port view writes second bank
// - First view writes first bank; both read second
// - View selects ignored while address enable set
// - Second view steers pin 3..0 control remote
// - Frequency write starts window of value x 40 ns (four clocks per unit)
// - Frequency read returns last window's edge count
// - Edge count holds at 0xff
`timescale 1ns/1ps
`default_nettype none
module port_select_status_regs
  import port_select_pkg::*;
(
  input wire logic core_clk_i, // Oscillator clock, 100 MHz
  input wire logic rst_i, // Synchronous reset, active high
  input wire reg_req_type req_i, // Decoded serial bus access
  input wire logic [6:0] primary_bus_address_i, // Primary 7-bit address
  input wire logic bist_start_i, // Self-test run starts
  input wire logic bist_active_i, // Self-test mode active
  input wire logic bist_count_clear_i, // Counter clear bit written
  input wire logic crc_err_first_i, // CRC error seen, first port
  input wire logic crc_err_second_i, // CRC error seen, second port
  input wire logic [PIN_COUNT-1:0] general_pin_i, // Local pin levels
  input wire logic [REMOTE_PIN_COUNT-1:0] remote_pin_i, // Second link pins 3..0
  input wire logic pixel_clk_i, // Pixel clock, sampled
  output reg_resp_type resp_o, // Answer, one cycle after request
  output logic pin_ctrl_remote_o, // Pin 3..0 control goes remote
  output logic second_address_active_o, // Second address responding
  output logic freq_busy_o // Frequency window running
);

  logic [7:0] port_select;
  logic [7:0] next_port_select;
  logic [PIN_COUNT-1:0] pin_snap;
  logic [REMOTE_PIN_COUNT-1:0] remote_snap;
  logic pix_prev;
  logic [7:0] crc_count_first;
  logic [7:0] crc_count_second;
  logic [7:0] edge_count;
  freq_state_type freq_state;
  freq_state_type next_freq_state;
  logic [TIMER_W-1:0] timer;
  logic [TIMER_W-1:0] next_timer;
  reg_resp_type next_resp;
  logic hit_primary;
  logic hit_second;
  logic read_second;
  logic [1:0] bank_write;
  logic reg_write;
  logic freq_write;
  logic crc_clear;
  logic pix_edge;
  logic first_view;
  logic second_view;
  logic addr2_en;

  // True when the register offset belongs to this slice
  function automatic logic in_slice(input logic [7:0] addr);
    in_slice = (addr >= ADDR_BC_ERR_COUNT) && (addr <= ADDR_FREQ_COUNTER);
  endfunction

  // True for a write to the given offset
  function automatic logic wr_to(input logic wr, input logic [7:0] addr, input logic [7:0] ofs);
    wr_to = wr && (addr == ofs);
  endfunction

  // Effective view selects
  assign addr2_en = port_select[SEL_ADDR2_BIT];
  assign first_view = port_select[SEL_FIRST_BIT] && !addr2_en;
  assign second_view = port_select[SEL_SECOND_BIT] && !addr2_en;

  // Bus address decode
  assign hit_primary = req_i.valid && (req_i.dev_addr == primary_bus_address_i);
  // second address at primary plus one
  assign hit_second = req_i.valid && addr2_en && (req_i.dev_addr == (primary_bus_address_i + 7'h01));

  // Bank steering for reads and writes
  always_comb
  begin
    read_second = 1'b0;
    bank_write = 2'h0;
    if (hit_second)
    begin
      read_second = 1'b1;
      bank_write = BANK_SECOND;
    end
    else if (hit_primary)
    begin
      // first view writes, both read second
      read_second = second_view;
      bank_write = {second_view, first_view || !second_view};
    end
  end

  assign reg_write = (hit_primary || hit_second) && req_i.write;
  assign freq_write = wr_to(reg_write, req_i.reg_addr, ADDR_FREQ_COUNTER);
  assign pix_edge = pixel_clk_i && !pix_prev;
  // clear on start or clear bit
  assign crc_clear = bist_start_i || bist_count_clear_i;

  sat_counter8 u_crc_first
  (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .clear_i(crc_clear),
    .inc_i(bist_active_i && crc_err_first_i),
    .count_o(crc_count_first)
  );

  sat_counter8 u_crc_second
  (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .clear_i(crc_clear),
    .inc_i(bist_active_i && crc_err_second_i),
    .count_o(crc_count_second)
  );

  sat_counter8 u_edge_count
  (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .clear_i(freq_write),
    .inc_i((freq_state == FREQ_MEASURE) && pix_edge),
    .count_o(edge_count)
  );

  // Port select register
  always_comb
  begin
    next_port_select = port_select;
    if (wr_to(reg_write, req_i.reg_addr, ADDR_PORT_SELECT))
      next_port_select = req_i.wdata & SEL_WRITE_MASK;
  end

  always_comb
  begin
    next_freq_state = freq_state;
    next_timer = timer;
    if (freq_write)
    begin
      next_timer = TIMER_W'(req_i.wdata * FREQ_UNIT_CYCLES);
      next_freq_state = (req_i.wdata == RESET_ZERO) ? FREQ_IDLE : FREQ_MEASURE;
    end
    else
    begin
      case (freq_state)
        FREQ_IDLE:
          next_timer = timer;
        FREQ_MEASURE:
        begin
          next_timer = timer - TIMER_ONE;
          if (timer == TIMER_ONE)
            next_freq_state = FREQ_IDLE;
        end
        default:
          next_freq_state = FREQ_IDLE;
      endcase
    end
  end

  // Read data and answer
  always_comb
  begin
    next_resp = '0;
    next_resp.ack = hit_primary || hit_second;
    next_resp.bank_write = req_i.write ? bank_write : 2'h0;
    next_resp.read_second = read_second;
    if ((hit_primary || hit_second) && !req_i.write && in_slice(req_i.reg_addr))
    begin
      next_resp.rd_valid = 1'b1;
      case (req_i.reg_addr)
        ADDR_BC_ERR_COUNT:
          next_resp.rdata = read_second ? crc_count_second : crc_count_first;
        ADDR_PIN_STATUS_LOW:
          next_resp.rdata = {pin_snap[7:5], 1'b0,
                             read_second ? remote_snap : pin_snap[3:0]};
        ADDR_PIN_STATUS_HIGH:
          next_resp.rdata = {7'h00, pin_snap[8]};
        ADDR_PORT_SELECT:
          next_resp.rdata = port_select;
        ADDR_FREQ_COUNTER:
          next_resp.rdata = edge_count;
        default:
          next_resp.rdata = RESET_ZERO;
      endcase
    end
  end

  // Register everything
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      port_select <= RESET_PORT_SELECT;
      pin_snap <= '0;
      remote_snap <= '0;
      pix_prev <= 1'b0;
      freq_state <= FREQ_IDLE;
      timer <= '0;
      resp_o <= '0;
      pin_ctrl_remote_o <= 1'b0;
      second_address_active_o <= 1'b0;
      freq_busy_o <= 1'b0;
    end
    else
    begin
      port_select <= next_port_select;
      pin_snap <= general_pin_i;
      remote_snap <= remote_pin_i;
      pix_prev <= pixel_clk_i;
      freq_state <= next_freq_state;
      timer <= next_timer;
      resp_o <= next_resp;
      pin_ctrl_remote_o <= next_port_select[SEL_SECOND_BIT] && !next_port_select[SEL_ADDR2_BIT];
      second_address_active_o <= next_port_select[SEL_ADDR2_BIT];
      freq_busy_o <= (next_freq_state == FREQ_MEASURE);
    end
  end

  // Checks
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  a_crc_saturate: assert property (bist_active_i && crc_err_first_i && !crc_clear && crc_count_first == COUNT_MAX |=> crc_count_first == COUNT_MAX) else $error("crc count passed ceiling");
  a_crc_clear_start: assert property (crc_clear |=> crc_count_first == 8'h00 && crc_count_second == 8'h00) else $error("crc count not cleared");
  a_crc_view_read: assert property (hit_primary && !req_i.write && req_i.reg_addr == ADDR_BC_ERR_COUNT && second_view |=> resp_o.rd_valid && resp_o.rdata == $past(crc_count_second)) else $error("wrong port count read");
  a_pin_low_layout: assert property (hit_primary && !req_i.write && req_i.reg_addr == ADDR_PIN_STATUS_LOW && !second_view ##1 1'b1 |-> resp_o.rdata == {$past(general_pin_i[7:5], 2), 1'b0, $past(general_pin_i[3:0], 2)}) else $error("pin status low wrong");
  a_pin_high_layout: assert property (hit_primary && !req_i.write && req_i.reg_addr == ADDR_PIN_STATUS_HIGH |=> resp_o.rdata[7:1] == 7'h00 && resp_o.rdata[0] == $past(pin_snap[8])) else $error("pin status high wrong");
  a_pin_remote_view: assert property (hit_primary && !req_i.write && req_i.reg_addr == ADDR_PIN_STATUS_LOW && second_view |=> resp_o.rdata[3:0] == $past(remote_snap)) else $error("remote pins not shown");
  a_second_address: assert property (req_i.valid && addr2_en && req_i.dev_addr == primary_bus_address_i + 7'h01 |=> resp_o.ack && resp_o.read_second) else $error("second address ignored");
  a_second_view_write: assert property (hit_primary && req_i.write && second_view |=> resp_o.bank_write[1]) else $error("second bank not written");
  a_both_read_second: assert property (hit_primary && !req_i.write && first_view && second_view |=> resp_o.read_second) else $error("both selects not reading second");
  a_select_ignored: assert property (hit_primary && req_i.write && addr2_en |=> resp_o.bank_write == BANK_FIRST) else $error("selects not ignored");
  a_pin_ctrl_redirect: assert property (pin_ctrl_remote_o == second_view) else $error("pin control redirect wrong");
  a_freq_window_end: assert property (freq_state == FREQ_MEASURE && timer == TIMER_ONE && !freq_write |=> freq_state == FREQ_IDLE && !freq_busy_o) else $error("window did not end");
  a_freq_restart: assert property (freq_write && req_i.wdata != 8'h00 |=> edge_count == 8'h00 && freq_busy_o && timer == TIMER_W'($past(req_i.wdata) * FREQ_UNIT_CYCLES)) else $error("window not restarted");
  a_edge_hold: assert property (edge_count == COUNT_MAX && !freq_write |=> edge_count == COUNT_MAX) else $error("edge count left ceiling");

  c_crc_full: cover property (crc_count_first == COUNT_MAX);
  c_second_addr_read: cover property (hit_second && !req_i.write);
  c_window_done: cover property (freq_state == FREQ_MEASURE ##1 freq_state == FREQ_IDLE);
  c_edge_full: cover property (edge_count == COUNT_MAX);

endmodule
`default_nettype wire

// ---- inc/port_select_pkg.sv ----
package port_select_pkg;

  // Register offsets on the serial control bus
  localparam logic [7:0] ADDR_BC_ERR_COUNT = 8'h1b;
  localparam logic [7:0] ADDR_PIN_STATUS_LOW = 8'h1c;
  localparam logic [7:0] ADDR_PIN_STATUS_HIGH = 8'h1d;
  localparam logic [7:0] ADDR_PORT_SELECT = 8'h1e;
  localparam logic [7:0] ADDR_FREQ_COUNTER = 8'h1f;

  // Values after reset
  localparam logic [7:0] RESET_PORT_SELECT = 8'h01;
  localparam logic [7:0] RESET_ZERO = 8'h00;

  // Port select field positions and writable mask
  localparam int SEL_FIRST_BIT = 0;
  localparam int SEL_SECOND_BIT = 1;
  localparam int SEL_ADDR2_BIT = 2;
  localparam logic [7:0] SEL_WRITE_MASK = 8'h07;

  // Pin status layout
  localparam int PIN_COUNT = 9;
  localparam int REMOTE_PIN_COUNT = 4;

  // Saturating counter ceiling
  localparam logic [7:0] COUNT_MAX = 8'hff;

  // Bank select codes: bit 0 first port, bit 1 second port
  localparam logic [1:0] BANK_FIRST = 2'h1;
  localparam logic [1:0] BANK_SECOND = 2'h2;

  // Frequency window timing: one written unit is 40 ns, four oscillator periods
  localparam int FREQ_UNIT_NS = 40;
  localparam int CLK_PERIOD_NS = 10;
  localparam int FREQ_UNIT_CYCLES = (FREQ_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W = 10;
  localparam logic [TIMER_W-1:0] TIMER_ONE = 10'h001;

  typedef enum logic
  {
    FREQ_IDLE = 1'b0,
    FREQ_MEASURE = 1'b1
  } freq_state_type;

  // One decoded access from the serial control bus
  typedef struct packed
  {
    logic valid;
    logic write;
    logic [6:0] dev_addr;
    logic [7:0] reg_addr;
    logic [7:0] wdata;
  } reg_req_type;

  // Answer to an access
  typedef struct packed
  {
    logic ack;
    logic rd_valid;
    logic [7:0] rdata;
    logic [1:0] bank_write;
    logic read_second;
  } reg_resp_type;

endpackage

// ---- rtl/sat_counter8.sv ----
`timescale 1ns/1ps
`default_nettype none
module sat_counter8
  import port_select_pkg::*;
(
  input wire logic core_clk_i, // Oscillator clock
  input wire logic rst_i, // Synchronous reset
  input wire logic clear_i, // Clear to zero, wins over count
  input wire logic inc_i, // Count one event
  output logic [7:0] count_o // Current count
);

  logic [7:0] next_count;

  // Count up and stop at the ceiling
  always_comb
  begin
    next_count = count_o;
    if (clear_i)
      next_count = RESET_ZERO;
    else if (inc_i && (count_o != COUNT_MAX))
      next_count = count_o + 8'h01;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      count_o <= RESET_ZERO;
    else
      count_o <= next_count;
  end

endmodule
`default_nettype wire

// ---- sim/host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module host_model
  import port_select_pkg::*;
(
  input wire logic core_clk_i, // Oscillator clock
  input wire reg_resp_type resp_i, // Device answer
  output reg_req_type req_o // Access to the device
);
  initial req_o = '0;
  // One access; idle fields get the inverse so nothing stale survives
  task automatic access(input logic wr, input logic [6:0] dev, input logic [7:0] ra,
    input logic [7:0] wd, output reg_resp_type rsp);
    rsp = '0;
    @(negedge core_clk_i);
    req_o <= '{1'b1, wr, dev, ra, wd};
    repeat (2)
    begin
      @(negedge core_clk_i);
      req_o <= '{1'b0, 1'b0, ~dev, ~ra, ~wd};
      if (resp_i.ack === 1'b1)
        rsp = resp_i;
    end
  endtask
endmodule
`default_nettype wire

// ---- sim/port_select_status_regs_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module port_select_status_regs_tb_top
  import port_select_pkg::*;
;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  reg_req_type req;
  reg_resp_type resp;
  reg_resp_type r;
  logic [6:0] pa = 7'h7f;
  logic bstart = 1'b0;
  logic bact = 1'b0;
  logic bclr = 1'b0;
  logic e0 = 1'b0;
  logic e1 = 1'b0;
  logic pix = 1'b0;
  logic [8:0] gp = 9'h000;
  logic [3:0] rp = 4'h0;
  logic ctl;
  logic a2;
  logic busy;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  int busy_cycles = 0;
  int n;
  logic [7:0] sels [4] = '{8'h01, 8'h02, 8'h03, 8'h00};
  logic [7:0] steer [4] = '{8'h0a, 8'h0d, 8'h0f, 8'h0a};

  port_select_status_regs port_select_status_regs_i (.core_clk_i(core_clk_i),
    .rst_i(rst_i), .req_i(req), .primary_bus_address_i(pa), .bist_start_i(bstart),
    .bist_active_i(bact), .bist_count_clear_i(bclr), .crc_err_first_i(e0),
    .crc_err_second_i(e1), .general_pin_i(gp), .remote_pin_i(rp), .pixel_clk_i(pix),
    .resp_o(resp), .pin_ctrl_remote_o(ctl), .second_address_active_o(a2),
    .freq_busy_o(busy));
  host_model host_model_i (.core_clk_i(core_clk_i), .resp_i(resp), .req_o(req));

  // Clock, free-running pixel clock, busy tally and hang guard
  always #5 core_clk_i = ~core_clk_i;
  always @(negedge core_clk_i) pix <= ~pix;
  // Tally on the falling edge so busy has settled
  always @(negedge core_clk_i)
  begin
    busy_cycles += (busy === 1'b1);
    cycles++;
    if (cycles == 6000)
    begin
      mismatches++;
      conclude();
    end
  end

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] ra, input logic [7:0] exp);
    host_model_i.access(1'b0, pa, ra, 8'h00, r);
    chk(r.rdata, exp);
    chk({7'h00, r.rd_valid}, 8'h01);
  endtask
  task automatic wr(input logic [7:0] ra, input logic [7:0] wd);
    host_model_i.access(1'b1, pa, ra, wd, r);
    chk({7'h00, r.ack}, 8'h01);
  endtask
  // One-cycle pulse on self-test start or on the clear bit
  task automatic pulse(input logic start);
    @(negedge core_clk_i);
    if (start)
      bstart = 1'b1;
    else
      bclr = 1'b1;
    @(negedge core_clk_i);
    bstart = 1'b0;
    bclr = 1'b0;
  endtask
  task automatic errs(input int k, input logic second);
    repeat (k)
    begin
      @(negedge core_clk_i);
      e0 = ~second;
      e1 = second;
    end
    @(negedge core_clk_i);
    e0 = 1'b0;
    e1 = 1'b0;
  endtask
  task automatic wait_idle;
    n = 0;
    while (busy !== 1'b0 && n < 1000)
    begin
      @(negedge core_clk_i);
      n++;
    end
  endtask

  // Values and levels straight after reset
  task automatic t_reset;
    chk({5'h00, ctl, a2, busy}, 8'h00);
    rd(ADDR_PORT_SELECT, RESET_PORT_SELECT);
    rd(ADDR_BC_ERR_COUNT, RESET_ZERO);
    rd(ADDR_PIN_STATUS_LOW, RESET_ZERO);
    rd(ADDR_FREQ_COUNTER, RESET_ZERO);
  endtask
  // Per-port counts, saturation, clears, read-only
  task automatic t_crc;
    bact = 1'b1;
    errs(3, 1'b0);
    errs(2, 1'b1);
    rd(ADDR_BC_ERR_COUNT, 8'h03);
    wr(ADDR_PORT_SELECT, 8'h02);
    rd(ADDR_BC_ERR_COUNT, 8'h02);
    wr(ADDR_PORT_SELECT, 8'h01);
    errs(300, 1'b0);
    rd(ADDR_BC_ERR_COUNT, 8'hff);
    wr(ADDR_BC_ERR_COUNT, 8'h10);
    rd(ADDR_BC_ERR_COUNT, 8'hff);
    pulse(1'b0);
    rd(ADDR_BC_ERR_COUNT, 8'h00);
    errs(4, 1'b0);
    pulse(1'b1);
    rd(ADDR_BC_ERR_COUNT, 8'h00);
    bact = 1'b0;
    errs(2, 1'b0);
    rd(ADDR_BC_ERR_COUNT, 8'h00);
  endtask
  // Pin layout, remote view, control steering
  task automatic t_pins;
    gp = 9'h1b5;
    rp = 4'ha;
    rd(ADDR_PIN_STATUS_LOW, 8'ha5);
    rd(ADDR_PIN_STATUS_HIGH, 8'h01);
    wr(ADDR_PORT_SELECT, 8'h02);
    gp = 9'h04a;
    rp = 4'h5;
    rd(ADDR_PIN_STATUS_LOW, 8'h45);
    rd(ADDR_PIN_STATUS_HIGH, 8'h00);
    chk({7'h00, ctl}, 8'h01);
    wr(ADDR_PORT_SELECT, 8'h06);
    rd(ADDR_PIN_STATUS_LOW, 8'h4a);
    chk({6'h00, ctl, a2}, 8'h01);
    wr(ADDR_PORT_SELECT, 8'h01);
  endtask
  // Bank steering per select code and second address
  task automatic t_steer;
    for (int i = 0; i < 4; i++)
    begin
      wr(ADDR_PORT_SELECT, sels[i]);
      host_model_i.access(1'b1, pa, 8'h40, 8'h00, r);
      chk({4'h0, r.ack, r.bank_write, r.read_second}, steer[i]);
    end
    host_model_i.access(1'b0, pa, 8'h40, 8'h00, r);
    chk({r.rdata[6:0], r.rd_valid}, 8'h00);
    host_model_i.access(1'b1, pa + 7'h01, 8'h40, 8'h00, r);
    chk({7'h00, r.ack}, 8'h00);
    wr(ADDR_PORT_SELECT, 8'hff);
    rd(ADDR_PORT_SELECT, 8'h07);
    host_model_i.access(1'b1, pa + 7'h01, 8'h40, 8'h00, r);
    chk({4'h0, r.ack, r.bank_write, r.read_second}, 8'h0d);
    // Read through the second address shows the remote pins
    host_model_i.access(1'b0, pa + 7'h01, ADDR_PIN_STATUS_LOW, 8'h00, r);
    chk(r.rdata, 8'h45);
    chk({6'h00, r.rd_valid, r.read_second}, 8'h03);
    host_model_i.access(1'b1, pa, 8'h40, 8'h00, r);
    chk({4'h0, r.ack, r.bank_write, r.read_second}, 8'h0a);
    wr(ADDR_PORT_SELECT, 8'h01);
  endtask
  // Window length, edge count, restart, saturation, zero
  task automatic t_freq;
    busy_cycles = 0;
    wr(ADDR_FREQ_COUNTER, 8'h05);
    wait_idle();
    chk(busy_cycles[7:0], 8'd20);
    rd(ADDR_FREQ_COUNTER, 8'h0a);
    wr(ADDR_FREQ_COUNTER, 8'h80);
    repeat (10) @(negedge core_clk_i);
    wr(ADDR_FREQ_COUNTER, 8'h02);
    wait_idle();
    rd(ADDR_FREQ_COUNTER, 8'h04);
    wr(ADDR_FREQ_COUNTER, 8'h80);
    wait_idle();
    rd(ADDR_FREQ_COUNTER, 8'hff);
    wr(ADDR_FREQ_COUNTER, 8'h80);
    wr(ADDR_FREQ_COUNTER, 8'h00);
    chk({7'h00, busy}, 8'h00);
    rd(ADDR_FREQ_COUNTER, 8'h00);
  endtask

  initial
  begin
    repeat (12) @(negedge core_clk_i);
    rst_i = 1'b0;
    t_reset();
    t_crc();
    t_pins();
    t_steer();
    t_freq();
    conclude();
  end
endmodule
`default_nettype wire
